// File: hw/stat_pkg.sv
/*
 * shared constants for the analyzer statistics block and its frame source
 * assumes a 12-bit byte address space on the register bus
 */
package stat_pkg;
    // ------------------------------------------------------------
    // sizes
    // ------------------------------------------------------------
    localparam int NUM_PORTS = 4;
    localparam int PORT_W = 2;
    localparam int PORT_CNTS = 4;
    localparam int NUM_PRIOS = 8;
    localparam int PRIO_W = 3;
    localparam int QUEUE_CNTS = 2;
    localparam int NUM_QUEUES = NUM_PORTS * NUM_PRIOS;
    localparam int PCNT_TOTAL = NUM_PORTS * PORT_CNTS;
    localparam int QCNT_TOTAL = NUM_QUEUES * QUEUE_CNTS;
    localparam int CNT_W = 40;
    localparam int LOW_W = 32;
    localparam int HIGH_W = 8;
    localparam int EVT_W = 12;
    localparam int QEVT_W = 2;
    localparam int BYTES_W = 14;
    localparam int CFG_W = 12;
    localparam int ADDR_W = 12;

    // ------------------------------------------------------------
    // register offsets (byte addresses)
    // ------------------------------------------------------------
    localparam logic [11:0] INIT_OFF = 12'h000;
    localparam logic [11:0] QMODE_OFF = 12'h010;
    localparam logic [11:0] QEVSEL_OFF = 12'h018;
    localparam logic [11:0] PEVSEL_OFF = 12'h020;
    localparam logic [11:0] PCFG_OFF = 12'h100;
    localparam logic [11:0] PCNT_OFF = 12'h200;
    localparam logic [11:0] PFLAG_OFF = 12'h300;
    localparam logic [11:0] QCNT_OFF = 12'h400;
    localparam logic [11:0] QCNT_END = 12'h600;

    // ------------------------------------------------------------
    // port_counter_config fields and reset values
    // ------------------------------------------------------------
    localparam int CFG_PRIO_LSB = 0;
    localparam int CFG_KIND_LSB = 8;
    localparam int CFG_BYTE_BIT = 11;
    localparam logic [11:0] PCFG_RESET = 12'h000;
    localparam logic [11:0] PEVSEL_RESET = 12'h000;
    localparam logic [1:0] QEVSEL_RESET = 2'h0;
    localparam logic QMODE_RESET = 1'b0;

    // queue event bits
    localparam int QEVT_PASSED = 0;
    localparam int QEVT_DROPPED = 1;

    // frame_kind_selector codes
    localparam logic [2:0] KIND_OK_NOMATCH = 3'h0;
    localparam logic [2:0] KIND_OK_MATCH = 3'h1;
    localparam logic [2:0] KIND_ERR_MATCH = 3'h2;
    localparam logic [2:0] KIND_ANY_MATCH = 3'h3;
    localparam logic [2:0] KIND_ERR_NOMATCH = 3'h4;
    localparam logic [2:0] KIND_ERR_ANY = 3'h5;
endpackage : stat_pkg

// File: hw/stat_link_if.sv
/*
 * frame event link between the analyzer stages and the statistics block
 * assumes both ends run on ref_clk
 */
`timescale 1ns/10ps
`default_nettype none
interface stat_link_if (
    input wire logic ref_clk,
    input wire logic rst_b
);
    import stat_pkg::*;
    logic frm_valid;
    logic frm_ready;
    logic [PORT_W-1:0] frm_port;
    logic [PRIO_W-1:0] frm_prio;
    logic [EVT_W-1:0] frm_events;
    logic [QEVT_W-1:0] frm_qevents;
    logic frm_error;
    logic frm_no_dest;
    logic [BYTES_W-1:0] frm_bytes;

    modport stats (
        input frm_valid, frm_port, frm_prio, frm_events, frm_qevents,
        input frm_error, frm_no_dest, frm_bytes,
        output frm_ready
    );
    modport source (
        output frm_valid, frm_port, frm_prio, frm_events, frm_qevents,
        output frm_error, frm_no_dest, frm_bytes,
        input frm_ready
    );
endinterface : stat_link_if
`default_nettype wire

// File: hw/frame_event_source.sv
/*
 * analyzer-side end: holds one frame record and presents it on the link
 * assumes the user side follows valid/ready and the link shares ref_clk
 */
`timescale 1ns/10ps
`default_nettype none
module frame_event_source (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic req_valid,
    output logic req_ready,
    input wire logic [stat_pkg::PORT_W-1:0] req_port,
    input wire logic [stat_pkg::PRIO_W-1:0] req_prio,
    input wire logic [stat_pkg::EVT_W-1:0] req_events,
    input wire logic [stat_pkg::QEVT_W-1:0] req_qevents,
    input wire logic req_error,
    input wire logic req_no_dest,
    input wire logic [stat_pkg::BYTES_W-1:0] req_bytes,
    stat_link_if.source link
);
    import stat_pkg::*;

    // ------------------------------------------------------------
    // one-entry hold stage
    // ------------------------------------------------------------
    logic load;

    // accept when empty or when the held frame leaves this cycle
    assign req_ready = !link.frm_valid || link.frm_ready;
    assign load = req_valid && req_ready;

    // valid flag
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            link.frm_valid <= 1'b0;
        end else if (req_ready) begin
            link.frm_valid <= req_valid;
        end
    end

    // frame record, event vector kept as delivered by each stage
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            link.frm_port <= '0;
            link.frm_prio <= '0;
            link.frm_events <= '0;
            link.frm_qevents <= '0;
            link.frm_error <= 1'b0;
            link.frm_no_dest <= 1'b0;
            link.frm_bytes <= '0;
        end else if (load) begin
            link.frm_port <= req_port;
            link.frm_prio <= req_prio;
            link.frm_events <= req_events;
            link.frm_qevents <= req_qevents;
            link.frm_error <= req_error;
            link.frm_no_dest <= req_no_dest;
            link.frm_bytes <= req_bytes;
        end
    end
endmodule : frame_event_source
`default_nettype wire

// File: hw/analyzer_port_queue_statistics.sv
/*
 * port and queue frame statistics counters with an APB register slave
 * assumes APB on ref_clk and frame records from the link source modport
 */
// Functional notes
// - four 40-bit counters per ingress port
// - two 40-bit counters per queue
// - queue index is port times eight plus priority
// - 12-bit event vector per frame
// - init write clears counters and sticky bits
// - software inits before trusting counters
// - kinds 0,1,2: ok-nomatch, ok-match, err-match
// - kind 3 counts any matching frame
// - kind 4 err-nomatch, kind 5 any error
// - priority mask bit gates each port counter
// - byte mode adds length, else adds one
// - one shared event select per counter position
// - frame without destination counts as errored
// - counter split into low 32, high 8
// - low read latches high into shadow
// - software reads low then high
// - port counter written low then high
// - queue counter written high then low
// - shared byte/frame mode per queue position
// - queue events: passed or dropped by policer
// - shared queue event select per position
// - per-port sticky flags held until init
`timescale 1ns/10ps
`default_nettype none
module analyzer_port_queue_statistics (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [stat_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    stat_link_if.stats link
);
    import stat_pkg::*;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [CNT_W-1:0] pcnt_reg [PCNT_TOTAL];
    logic [CNT_W-1:0] qcnt_reg [QCNT_TOTAL];
    logic [CFG_W-1:0] pcfg_reg [PCNT_TOTAL];
    logic [EVT_W-1:0] pevsel_reg [PORT_CNTS];
    logic [QEVT_W-1:0] qevsel_reg [QUEUE_CNTS];
    logic [QUEUE_CNTS-1:0] qmode_reg;
    logic [EVT_W-1:0] pflag_reg [NUM_PORTS];
    logic [HIGH_W-1:0] shadow_reg;
    logic [LOW_W-1:0] plow_stage_reg;
    logic [HIGH_W-1:0] qhigh_stage_reg;
    logic [31:0] prdata_reg;
    logic pslverr_reg;

    // ------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------
    logic setup, wr, word_ok, hit, hi_half, init_wr, take;
    logic [31:0] rd_next;
    logic sel_init, sel_qmode, sel_qevsel, sel_pevsel, sel_pcfg, sel_pcnt, sel_pflag, sel_qcnt;
    logic [3:0] pidx_cfg, pidx_cnt;
    logic [5:0] qidx;

    assign setup = psel && !penable;
    assign wr = psel && penable && pwrite;
    assign word_ok = (paddr[1:0] == 2'h0);
    assign hi_half = paddr[2];
    assign pidx_cfg = paddr[5:2];
    assign pidx_cnt = paddr[6:3];
    assign qidx = paddr[8:3];

    // region select
    assign sel_init = word_ok && (paddr == INIT_OFF);
    assign sel_qmode = word_ok && (paddr[11:3] == QMODE_OFF[11:3]);
    assign sel_qevsel = word_ok && (paddr[11:3] == QEVSEL_OFF[11:3]);
    assign sel_pevsel = word_ok && (paddr[11:4] == PEVSEL_OFF[11:4]);
    assign sel_pcfg = word_ok && (paddr[11:6] == PCFG_OFF[11:6]);
    assign sel_pcnt = word_ok && (paddr[11:7] == PCNT_OFF[11:7]);
    assign sel_pflag = word_ok && (paddr[11:4] == PFLAG_OFF[11:4]);
    assign sel_qcnt = word_ok && (paddr >= QCNT_OFF) && (paddr < QCNT_END);

    // read data and hit
    always_comb begin
        rd_next = 32'h0;
        hit = 1'b1;
        if (sel_init) begin
            rd_next = 32'h0;
        end else if (sel_qmode) begin
            rd_next = {31'h0, qmode_reg[hi_half]};
        end else if (sel_qevsel) begin
            rd_next = {30'h0, qevsel_reg[hi_half]};
        end else if (sel_pevsel) begin
            rd_next = {20'h0, pevsel_reg[paddr[3:2]]};
        end else if (sel_pcfg) begin
            rd_next = {20'h0, pcfg_reg[pidx_cfg]};
        end else if (sel_pcnt) begin
            rd_next = hi_half ? {24'h0, shadow_reg} : pcnt_reg[pidx_cnt][LOW_W-1:0];
        end else if (sel_pflag) begin
            rd_next = {20'h0, pflag_reg[paddr[3:2]]};
        end else if (sel_qcnt) begin
            rd_next = hi_half ? {24'h0, shadow_reg} : qcnt_reg[qidx][LOW_W-1:0];
        end else begin
            hit = 1'b0;
        end
    end

    // answer in the first access cycle
    assign pready = psel && penable;
    assign prdata = prdata_reg;
    assign pslverr = pslverr_reg;

    // read data and error captured in setup
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            prdata_reg <= 32'h0;
            pslverr_reg <= 1'b0;
        end else if (setup) begin
            prdata_reg <= pwrite ? 32'h0 : rd_next;
            pslverr_reg <= !hit;
        end
    end

    // high part latched when the low part is read
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            shadow_reg <= '0;
        end else if (setup && !pwrite && !hi_half && sel_pcnt) begin
            shadow_reg <= pcnt_reg[pidx_cnt][CNT_W-1:LOW_W];
        end else if (setup && !pwrite && !hi_half && sel_qcnt) begin
            shadow_reg <= qcnt_reg[qidx][CNT_W-1:LOW_W];
        end
    end

    // ------------------------------------------------------------
    // configuration registers
    // ------------------------------------------------------------
    assign init_wr = wr && sel_init && pwdata[0];
    // frames held off in the init cycle so no event is lost to the clear
    assign link.frm_ready = !init_wr;
    assign take = link.frm_valid && link.frm_ready;

    // software-written settings
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            for (int i = 0; i < PCNT_TOTAL; i++) pcfg_reg[i] <= PCFG_RESET;
            for (int i = 0; i < PORT_CNTS; i++) pevsel_reg[i] <= PEVSEL_RESET;
            for (int i = 0; i < QUEUE_CNTS; i++) qevsel_reg[i] <= QEVSEL_RESET;
            qmode_reg <= {QUEUE_CNTS{QMODE_RESET}};
        end else if (wr) begin
            if (sel_pcfg) begin
                pcfg_reg[pidx_cfg] <= pwdata[CFG_W-1:0];
            end else if (sel_pevsel) begin
                pevsel_reg[paddr[3:2]] <= pwdata[EVT_W-1:0];
            end else if (sel_qevsel) begin
                qevsel_reg[hi_half] <= pwdata[QEVT_W-1:0];
            end else if (sel_qmode) begin
                qmode_reg[hi_half] <= pwdata[0];
            end
        end
    end

    // write staging for the two-part counter writes
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            plow_stage_reg <= '0;
            qhigh_stage_reg <= '0;
        end else if (wr && sel_pcnt && !hi_half) begin
            plow_stage_reg <= pwdata;
        end else if (wr && sel_qcnt && hi_half) begin
            qhigh_stage_reg <= pwdata[HIGH_W-1:0];
        end
    end

    // ------------------------------------------------------------
    // per-counter qualification
    // ------------------------------------------------------------
    logic frame_err;
    logic [PORT_CNTS-1:0] pen;
    logic [CNT_W-1:0] pinc [PORT_CNTS];
    logic [QUEUE_CNTS-1:0] qen;
    logic [CNT_W-1:0] qinc [QUEUE_CNTS];
    logic [CNT_W-1:0] byte_inc;
    logic [4:0] qbase;

    assign frame_err = link.frm_error || link.frm_no_dest;
    assign byte_inc = {{(CNT_W-BYTES_W){1'b0}}, link.frm_bytes};
    assign qbase = {link.frm_port, link.frm_prio};

    genvar k;
    generate
        for (k = 0; k < PORT_CNTS; k++) begin : g_port
            logic [CFG_W-1:0] cfg;
            logic match;
            logic hit_kind;
            assign cfg = pcfg_reg[{link.frm_port, 2'(k)}];
            assign match = |(pevsel_reg[k] & link.frm_events);
            // frame kind against error and match
            always_comb begin
                case (cfg[CFG_KIND_LSB +: 3])
                    KIND_OK_NOMATCH: hit_kind = !frame_err && !match;
                    KIND_OK_MATCH: hit_kind = !frame_err && match;
                    KIND_ERR_MATCH: hit_kind = frame_err && match;
                    KIND_ANY_MATCH: hit_kind = match;
                    KIND_ERR_NOMATCH: hit_kind = frame_err && !match;
                    KIND_ERR_ANY: hit_kind = frame_err;
                    default: hit_kind = 1'b0;
                endcase
            end
            assign pen[k] = take && cfg[CFG_PRIO_LSB + link.frm_prio] && hit_kind;
            assign pinc[k] = cfg[CFG_BYTE_BIT] ? byte_inc : 40'h1;
        end
        for (k = 0; k < QUEUE_CNTS; k++) begin : g_queue
            assign qen[k] = take && |(qevsel_reg[k] & link.frm_qevents);
            assign qinc[k] = qmode_reg[k] ? byte_inc : 40'h1;
        end
    endgenerate

    // ------------------------------------------------------------
    // counters
    // ------------------------------------------------------------
    // counting, init clear and software writes; a write lands last
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            for (int i = 0; i < PCNT_TOTAL; i++) pcnt_reg[i] <= '0;
            for (int i = 0; i < QCNT_TOTAL; i++) qcnt_reg[i] <= '0;
        end else if (init_wr) begin
            for (int i = 0; i < PCNT_TOTAL; i++) pcnt_reg[i] <= '0;
            for (int i = 0; i < QCNT_TOTAL; i++) qcnt_reg[i] <= '0;
        end else begin
            for (int i = 0; i < PORT_CNTS; i++) begin
                if (pen[i]) begin
                    // sum kept at 40 bits so it wraps
                    pcnt_reg[{link.frm_port, 2'(i)}] <=
                        pcnt_reg[{link.frm_port, 2'(i)}] + pinc[i];
                end
            end
            for (int i = 0; i < QUEUE_CNTS; i++) begin
                if (qen[i]) begin
                    qcnt_reg[{qbase, 1'(i)}] <= qcnt_reg[{qbase, 1'(i)}] + qinc[i];
                end
            end
            if (wr && sel_pcnt && hi_half) begin
                pcnt_reg[pidx_cnt] <= {pwdata[HIGH_W-1:0], plow_stage_reg};
            end
            if (wr && sel_qcnt && !hi_half) begin
                qcnt_reg[qidx] <= {qhigh_stage_reg, pwdata};
            end
        end
    end

    // per-port sticky event flags
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            for (int i = 0; i < NUM_PORTS; i++) pflag_reg[i] <= '0;
        end else if (init_wr) begin
            for (int i = 0; i < NUM_PORTS; i++) pflag_reg[i] <= '0;
        end else if (take) begin
            pflag_reg[link.frm_port] <= pflag_reg[link.frm_port] | link.frm_events;
        end
    end
endmodule : analyzer_port_queue_statistics
`default_nettype wire

// File: bench/stat_link_chk.sv
/* link checker: stalled frames hold, init stalls one cycle
   assumes one clock domain, rst_b active low */
`timescale 1ns/10ps
`default_nettype none
module stat_link_chk (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic frm_valid,
    input wire logic frm_ready,
    input wire logic [stat_pkg::PORT_W-1:0] frm_port,
    input wire logic [stat_pkg::PRIO_W-1:0] frm_prio,
    input wire logic [stat_pkg::EVT_W-1:0] frm_events,
    input wire logic [stat_pkg::QEVT_W-1:0] frm_qevents,
    input wire logic frm_error,
    input wire logic frm_no_dest,
    input wire logic [stat_pkg::BYTES_W-1:0] frm_bytes
);
    import stat_pkg::*;
    // ----------------------------------------
    // link properties
    // ----------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    wire logic stall = frm_valid && !frm_ready;
    a_valid_hold: assert property (stall |=> frm_valid)
        else $error("frame dropped while stalled");
    a_dest_hold: assert property (stall |=> $stable({frm_port, frm_prio}))
        else $error("port or priority changed while stalled");
    a_event_hold: assert property (stall |=> $stable(frm_events))
        else $error("events changed while stalled");
    a_bytes_hold: assert property (stall |=> $stable(frm_bytes))
        else $error("length changed while stalled");
    a_error_hold: assert property (stall |=> $stable({frm_error, frm_no_dest}))
        else $error("error bits changed while stalled");
    a_qevent_hold: assert property (stall |=> $stable(frm_qevents))
        else $error("queue events changed while stalled");
    a_init_short: assert property (!frm_ready |=> frm_ready)
        else $error("link refused for more than one cycle");
    a_reset_idle: assert property ($rose(rst_b) |-> !frm_valid && frm_ready)
        else $error("link not idle after reset");
endmodule : stat_link_chk
`default_nettype wire

// File: bench/analyzer_port_queue_statistics_tb.sv
/* bench for the statistics block with its frame source on one link
   assumes stat_pkg register map and a zero wait-state apb slave */
`timescale 1ns/10ps
`default_nettype none
module analyzer_port_queue_statistics_tb;
    import stat_pkg::*;
    logic ref_clk, rst_b, psel, penable, pwrite, pready, pslverr;
    logic req_valid, req_ready, req_error, req_no_dest, mdl_on;
    logic [11:0] paddr, req_events, flag_exp;
    logic [31:0] pwdata, prdata;
    logic [1:0] req_port, req_qevents, mport;
    logic [2:0] req_prio;
    logic [13:0] req_bytes;
    logic [15:0] lfsr;
    logic [32:0] exp_q[$];
    logic [32:0] msk_q[$];
    int failures, n_tests;
    logic [39:0] pexp[4];
    logic [39:0] qexp[32][2];
    logic [11:0] sel[4];
    logic [11:0] cfg[4];
    logic [1:0] qsel[2];
    logic qmode[2];
    // ----------------------------------------
    // clock, ends and checker
    // ----------------------------------------
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    stat_link_if u_stat_link_if (.ref_clk(ref_clk), .rst_b(rst_b));
    analyzer_port_queue_statistics u_analyzer_port_queue_statistics (.ref_clk(ref_clk),
        .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .link(u_stat_link_if.stats));
    frame_event_source u_frame_event_source (.ref_clk(ref_clk), .rst_b(rst_b),
        .req_valid(req_valid), .req_ready(req_ready), .req_port(req_port),
        .req_prio(req_prio), .req_events(req_events), .req_qevents(req_qevents),
        .req_error(req_error), .req_no_dest(req_no_dest), .req_bytes(req_bytes),
        .link(u_stat_link_if.source));
    stat_link_chk u_stat_link_chk (.ref_clk(ref_clk), .rst_b(rst_b),
        .frm_valid(u_stat_link_if.frm_valid), .frm_ready(u_stat_link_if.frm_ready),
        .frm_port(u_stat_link_if.frm_port), .frm_prio(u_stat_link_if.frm_prio),
        .frm_events(u_stat_link_if.frm_events), .frm_qevents(u_stat_link_if.frm_qevents),
        .frm_error(u_stat_link_if.frm_error), .frm_no_dest(u_stat_link_if.frm_no_dest),
        .frm_bytes(u_stat_link_if.frm_bytes));
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic [15:0] lfsr_step(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr_step
    function automatic logic kind_hit(input logic [2:0] c, input logic e, input logic m);
        case (c)
            KIND_OK_NOMATCH: return !e && !m;
            KIND_OK_MATCH: return !e && m;
            KIND_ERR_MATCH: return e && m;
            KIND_ANY_MATCH: return m;
            KIND_ERR_NOMATCH: return e && !m;
            KIND_ERR_ANY: return e;
            default: return 1'b0;
        endcase
    endfunction : kind_hit
    task automatic check(input logic [32:0] e, input logic [32:0] g, input logic [32:0] m);
        n_tests++;
        if ((g & m) !== (e & m)) begin
            failures++;
            $display("ERROR read data expected %h seen %h", e & m, g & m);
        end
    endtask : check
    task automatic complete_run();
        if (failures == 0 && n_tests > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : complete_run
    // apb transfer: setup, access until pready, release
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do @(posedge ref_clk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic rd(input logic [11:0] a, input logic [32:0] e, input logic [32:0] m);
        exp_q.push_back(e);
        msk_q.push_back(m);
        apb(1'b0, a, 32'h0);
    endtask : rd
    task automatic rd40(input logic [11:0] a, input logic [39:0] e);
        rd(a, {1'b0, e[31:0]}, 33'h1FFFFFFFF);
        rd(a + 12'h004, {25'h0, e[39:32]}, 33'h1FFFFFFFF);
    endtask : rd40
    task automatic init();
        apb(1'b1, INIT_OFF, 32'h1);
        pexp = '{default: '0};
        qexp = '{default: '0};
        flag_exp = 12'h000;
    endtask : init
    // one random frame, noted in the model, held until taken
    task automatic frame(input logic [1:0] p, input logic clean);
        logic [15:0] a;
        logic [15:0] b;
        logic [39:0] n;
        logic err;
        lfsr = lfsr_step(lfsr);
        a = lfsr & (clean ? 16'hFFE7 : 16'hFFFF);
        lfsr = lfsr_step(lfsr);
        b = lfsr;
        n = {26'h0, b[15:12], a[15:6]};
        err = a[3] | (a[4] & a[5]);
        req_valid <= 1'b1;
        req_port <= p;
        req_prio <= a[2:0];
        req_error <= a[3];
        req_no_dest <= a[4] & a[5];
        req_qevents <= a[7:6];
        req_events <= b[11:0];
        req_bytes <= n[13:0];
        if (mdl_on && p == mport) begin
            flag_exp |= b[11:0];
            for (int k = 0; k < 4; k++)
                if (cfg[k][a[2:0]] && kind_hit(cfg[k][10:8], err, |(sel[k] & b[11:0])))
                    pexp[k] += cfg[k][11] ? n : 40'h1;
        end
        for (int k = 0; k < 2; k++)
            if (|(qsel[k] & a[7:6]))
                qexp[8 * p + a[2:0]][k] += qmode[k] ? n : 40'h1;
        do @(posedge ref_clk); while (req_ready !== 1'b1);
    endtask : frame
    // ----------------------------------------
    // result monitor and watchdog
    // ----------------------------------------
    always @(posedge ref_clk) begin
        if (psel && penable && pready === 1'b1 && !pwrite && exp_q.size() > 0)
            check(exp_q.pop_front(), {pslverr, prdata}, msk_q.pop_front());
    end
    initial begin
        repeat (30000) @(posedge ref_clk);
        failures++;
        complete_run();
    end
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        {psel, penable, pwrite, req_valid, req_error, req_no_dest, mdl_on} = 7'h00;
        {paddr, req_events, pwdata, req_port, req_qevents, req_prio, req_bytes} = 77'h0;
        {failures, n_tests, lfsr} = {32'h0, 32'h0, 16'h78C4};
        mport = 2'd1;
        rst_b = 1'b0;
        repeat (20) @(posedge ref_clk);
        rst_b <= 1'b1;
        rd(PCFG_OFF + 12'h014, {21'h0, PCFG_RESET}, 33'h1FFFFFFFF);
        rd(PEVSEL_OFF + 12'h00C, {21'h0, PEVSEL_RESET}, 33'h1FFFFFFFF);
        rd(12'h700, 33'h100000000, 33'h100000000);
        rd(PCNT_OFF + 12'h002, 33'h100000000, 33'h100000000);
        init();
        for (int r = 0; r < 2; r++) begin
            mdl_on = 1'b1;
            for (int k = 0; k < 4; k++) begin
                lfsr = lfsr_step(lfsr);
                sel[k] = lfsr[11:0];
                cfg[k] = {lfsr[15], 3'(4 * r + k), lfsr[7:0] | 8'h11};
                apb(1'b1, PEVSEL_OFF + 12'(4 * k), {20'h0, sel[k]});
                apb(1'b1, PCFG_OFF + 12'(16 + 4 * k), {20'h0, cfg[k]});
            end
            for (int k = 0; k < 2; k++) begin
                qmode[k] = 1'(r + k);
                qsel[k] = r == 1 ? 2'h3 : 2'(k + 1);
                apb(1'b1, QMODE_OFF + 12'(4 * k), {31'h0, qmode[k]});
                apb(1'b1, QEVSEL_OFF + 12'(4 * k), {30'h0, qsel[k]});
            end
            @(posedge ref_clk);
            for (int f = 0; f < 24; f++)
                frame(f % 5 == 4 ? 2'd2 : 2'd1, 1'b0);
            req_valid <= 1'b0;
            repeat (3) @(posedge ref_clk);
            for (int k = 0; k < 4; k++)
                rd40(PCNT_OFF + 12'(32 + 8 * k), pexp[k]);
            rd(PFLAG_OFF + 12'h004, {21'h0, flag_exp}, 33'h1FFFFFFFF);
            for (int q = 8; q < 24; q++)
                for (int k = 0; k < 2; k++)
                    rd40(QCNT_OFF + 12'(16 * q + 8 * k), qexp[q][k]);
            init();
            rd40(PCNT_OFF + 12'h020, 40'h0);
            rd(PFLAG_OFF + 12'h004, 33'h0, 33'h1FFFFFFFF);
        end
        // port 0 counter 0 set to the top, one clean frame wraps it
        mport = 2'd0;
        sel[0] = 12'h000;
        cfg = '{12'h0FF, 12'h000, 12'h000, 12'h000};
        apb(1'b1, PEVSEL_OFF, 32'h0);
        apb(1'b1, PCFG_OFF, 32'h000000FF);
        apb(1'b1, PCNT_OFF, 32'hFFFFFFFF);
        apb(1'b1, PCNT_OFF + 12'h004, 32'h000000FF);
        rd40(PCNT_OFF, 40'hFFFFFFFFFF);
        pexp[0] = 40'hFFFFFFFFFF;
        @(posedge ref_clk);
        frame(2'd0, 1'b1);
        req_valid <= 1'b0;
        repeat (3) @(posedge ref_clk);
        rd40(PCNT_OFF, pexp[0]);
        apb(1'b1, PCNT_OFF, 32'h01234567);
        apb(1'b1, PCNT_OFF + 12'h004, 32'h000000AB);
        apb(1'b1, QCNT_OFF + 12'h004, 32'h00000012);
        apb(1'b1, QCNT_OFF, 32'h00000345);
        rd(PCNT_OFF, {1'b0, 32'h01234567}, 33'h1FFFFFFFF);
        rd(QCNT_OFF + 12'h004, {25'h0, 8'hAB}, 33'h1FFFFFFFF);
        rd40(QCNT_OFF, 40'h1200000345);
        // init write while a burst is pending on the link
        fork
            apb(1'b1, INIT_OFF, 32'h1);
            begin
                @(posedge ref_clk);
                for (int f = 0; f < 6; f++)
                    frame(2'd3, 1'b0);
                req_valid <= 1'b0;
            end
        join
        init();
        rd40(QCNT_OFF, 40'h0);
        @(posedge ref_clk);
        complete_run();
    end
endmodule : analyzer_port_queue_statistics_tb
`default_nettype wire
